// ==== rtl/ebpm_pkg.sv ====
// Purpose: constants and carriers for the shared-pin function mux
// Assumes: one clock, registers reached over a plain strobe port
// Notes: pin index 0..12 follows the order of the pin constants
// Function
// - software selects pull-up per general purpose pin
// - hold pins are port pins unless bus hold
// - hold request accepted only with bus hold
// - hold acknowledge driven only with bus hold
// - ready pin is port pin unless bus ready
// - ready input sampled only with bus ready
// - clock pin is port pin unless clock output
// - clock output driven only with bus clock
// - compare waveforms 4-7 share those four pins
// - address/data pins are port pins in single-chip
// - address/data pins are bus lines with bus
// - reload timer 1 output on address/data pin
// - serial 3 input and interrupt share pin
// - serial 3 output on address/data pin
// - serial 3 clock in or out on pin
// - capture 6, CAN receive, interrupt 9 share pin
// - sub-clock variants release two crystal pins
package ebpm_pkg;
    localparam int PIN_COUNT = 13;
    localparam int AD_COUNT = 6;
    localparam int CMP_COUNT = 4;
    localparam int ADDR_W = 4;
    // pin indices
    localparam int PIN_PORT3_BIT4 = 0;
    localparam int PIN_PORT3_BIT5 = 1;
    localparam int PIN_PORT3_BIT6 = 2;
    localparam int PIN_PORT3_BIT7 = 3;
    localparam int PIN_PORT4_BIT0 = 4;
    localparam int PIN_PORT4_BIT1 = 5;
    localparam int PIN_PORT4_BIT2 = 6;
    localparam int PIN_PORT1_BIT1 = 7;
    localparam int PIN_PORT1_BIT2 = 8;
    localparam int PIN_PORT1_BIT3 = 9;
    localparam int PIN_PORT1_BIT4 = 10;
    localparam int PIN_PORT1_BIT5 = 11;
    localparam int PIN_PORT1_BIT6 = 12;
    localparam int AD_BASE = PIN_PORT1_BIT1;
    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_DATA = 4'h1;
    localparam logic [ADDR_W-1:0] REG_DIR = 4'h2;
    localparam logic [ADDR_W-1:0] REG_PULL = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PIN = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h5;
    // control fields
    localparam int CTRL_EXT_BUS = 0;
    localparam int CTRL_HOLD = 1;
    localparam int CTRL_READY = 2;
    localparam int CTRL_CLKOUT = 3;
    localparam int CTRL_CMP_LSB = 4;
    localparam int CTRL_TIMER1 = 8;
    localparam int CTRL_SEROUT = 9;
    localparam int CTRL_SERCLK = 10;
    localparam int CTRL_BITS = 11;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 11'h000;
    localparam logic [PIN_COUNT-1:0] PORT_RESET = 13'h0000;
    // status fields
    localparam int STAT_HOLD_REQ = 0;
    localparam int STAT_READY = 1;
    localparam int STAT_EXT_BUS = 2;
    localparam int STAT_HOLD_ON = 3;
    localparam int STAT_READY_ON = 4;
    localparam int STAT_CLKOUT_ON = 5;
    localparam int STAT_BITS = 6;

    typedef enum logic [3:0] {
        ROLE_GPIO = 4'h1,
        ROLE_BUS = 4'h2,
        ROLE_ALT = 4'h4,
        ROLE_OFF = 4'h8
    } ebpm_role_e;

    typedef struct packed {
        logic [AD_COUNT-1:0] adOut;
        logic [AD_COUNT-1:0] adOe;
        logic holdAck;
        logic busClk;
    } ebpm_bus_s;

    typedef struct packed {
        logic [CMP_COUNT-1:0] cmpWave;
        logic timer1Out;
        logic serialOut;
        logic serialClkOut;
    } ebpm_periph_s;

    typedef struct packed {
        logic holdReq;
        logic ready;
        logic [AD_COUNT-1:0] adIn;
        logic serialIn;
        logic serialClkIn;
        logic irqLine9;
        logic irqLine11;
        logic capture6;
        logic canRx;
    } ebpm_core_in_s;
endpackage

// ==== rtl/ebpm_sync.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module ebpm_sync #(
    parameter int W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ebpm_pad_stage.sv ====
// Purpose: registers pad drive, enable and pull-up
// Assumes: next values computed by the mux
// Notes: pads released during reset
`timescale 1ns/100ps
`default_nettype none
module ebpm_pad_stage #(
    parameter int W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // next values
    input wire logic [W-1:0] next_out,
    input wire logic [W-1:0] next_oe,
    input wire logic [W-1:0] next_pull,
    // pads
    output logic [W-1:0] padOut,
    output logic [W-1:0] padOe,
    output logic [W-1:0] padPull
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            padOut <= '0;
            padOe <= '0;
            padPull <= '0;
        end else begin
            padOut <= next_out;
            padOe <= next_oe;
            padPull <= next_pull;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ebpm_pin_mux.sv ====
// Purpose: selects port, bus or peripheral role of shared pins
// Assumes: core side on clk, pins asynchronous
// Notes: all pin and core outputs are registered
`timescale 1ns/100ps
`default_nettype none
module ebpm_pin_mux
    import ebpm_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter bit HAS_SUBCLOCK = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // core side
    input wire ebpm_bus_s busOut,
    input wire ebpm_periph_s periphOut,
    output ebpm_core_in_s coreIn,
    // pins
    input wire logic [PIN_COUNT-1:0] pinIn,
    output logic [PIN_COUNT-1:0] pinOut,
    output logic [PIN_COUNT-1:0] pinOe,
    output logic [PIN_COUNT-1:0] pinPull
);
    generate
        if (DATA_W < PIN_COUNT || DATA_W < CTRL_BITS) begin : g_width_check
            $error("data width too narrow for pin registers");
        end
    endgenerate

    logic [CTRL_BITS-1:0] ctrl, next_ctrl;
    logic [PIN_COUNT-1:0] portData, next_portData;
    logic [PIN_COUNT-1:0] portDir, next_portDir;
    logic [PIN_COUNT-1:0] portPull, next_portPull;
    logic [DATA_W-1:0] next_regRdata;
    ebpm_core_in_s next_coreIn;
    logic [PIN_COUNT-1:0] pinSync;
    logic [PIN_COUNT-1:0] busDrive, busEnable, altDrive;
    logic [PIN_COUNT-1:0] next_out, next_oe, next_pull;
    logic [PIN_COUNT-1:0] pinLevel;
    logic [STAT_BITS-1:0] status;
    logic extBus, holdOn, readyOn, clkOn;

    function automatic ebpm_role_e pinRole(input int idx, input logic [CTRL_BITS-1:0] c);
        logic ext;
        ebpm_role_e role;
        ext = c[CTRL_EXT_BUS];
        role = ROLE_GPIO;
        if (HAS_SUBCLOCK && (idx == PIN_PORT4_BIT0 || idx == PIN_PORT4_BIT1)) begin
            role = ROLE_OFF;
        end else if (idx == PIN_PORT3_BIT4 || idx == PIN_PORT3_BIT5) begin
            if (ext && c[CTRL_HOLD]) begin
                role = ROLE_BUS;
            end else if (c[CTRL_CMP_LSB + idx]) begin
                role = ROLE_ALT;
            end
        end else if (idx == PIN_PORT3_BIT6) begin
            if (ext && c[CTRL_READY]) begin
                role = ROLE_BUS;
            end else if (c[CTRL_CMP_LSB + idx]) begin
                role = ROLE_ALT;
            end
        end else if (idx == PIN_PORT3_BIT7) begin
            if (ext && c[CTRL_CLKOUT]) begin
                role = ROLE_BUS;
            end else if (c[CTRL_CMP_LSB + idx]) begin
                role = ROLE_ALT;
            end
        end else if (idx >= AD_BASE) begin
            if (ext) begin
                role = ROLE_BUS;
            end else if ((idx == PIN_PORT1_BIT1 && c[CTRL_TIMER1]) ||
                         (idx == PIN_PORT1_BIT3 && c[CTRL_SEROUT]) ||
                         (idx == PIN_PORT1_BIT4 && c[CTRL_SERCLK])) begin
                role = ROLE_ALT;
            end
        end
        return role;
    endfunction

    ebpm_sync #(
        .W(PIN_COUNT)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(pinIn),
        .q(pinSync)
    );

    ebpm_pad_stage #(
        .W(PIN_COUNT)
    ) u_pads (
        .clk(clk),
        .rst_n(rst_n),
        .next_out(next_out),
        .next_oe(next_oe),
        .next_pull(next_pull),
        .padOut(pinOut),
        .padOe(pinOe),
        .padPull(pinPull)
    );

    // mode decode
    always_comb begin
        extBus = ctrl[CTRL_EXT_BUS];
        holdOn = extBus && ctrl[CTRL_HOLD];
        readyOn = extBus && ctrl[CTRL_READY];
        clkOn = extBus && ctrl[CTRL_CLKOUT];
    end

    // bus and peripheral sources per pin
    always_comb begin
        busDrive = '0;
        busEnable = '0;
        altDrive = '0;
        busDrive[PIN_PORT3_BIT5] = busOut.holdAck;
        busEnable[PIN_PORT3_BIT5] = 1'b1;
        busDrive[PIN_PORT3_BIT7] = busOut.busClk;
        busEnable[PIN_PORT3_BIT7] = 1'b1;
        busDrive[AD_BASE +: AD_COUNT] = busOut.adOut;
        busEnable[AD_BASE +: AD_COUNT] = busOut.adOe;
        altDrive[PIN_PORT3_BIT4 +: CMP_COUNT] = periphOut.cmpWave;
        altDrive[PIN_PORT1_BIT1] = periphOut.timer1Out;
        altDrive[PIN_PORT1_BIT3] = periphOut.serialOut;
        altDrive[PIN_PORT1_BIT4] = periphOut.serialClkOut;
    end

    // pad next values
    always_comb begin
        next_out = '0;
        next_oe = '0;
        next_pull = '0;
        for (int i = 0; i < PIN_COUNT; i++) begin
            case (pinRole(i, ctrl))
                ROLE_BUS: begin
                    next_out[i] = busDrive[i];
                    next_oe[i] = busEnable[i];
                end
                ROLE_ALT: begin
                    next_out[i] = altDrive[i];
                    next_oe[i] = 1'b1;
                end
                ROLE_GPIO: begin
                    next_out[i] = portData[i];
                    next_oe[i] = portDir[i];
                    next_pull[i] = portPull[i] && !portDir[i];
                end
                default: begin
                    next_out[i] = 1'b0;
                end
            endcase
        end
    end

    // pin levels seen by the core
    always_comb begin
        next_coreIn = '0;
        next_coreIn.holdReq = holdOn && pinSync[PIN_PORT3_BIT4];
        next_coreIn.ready = readyOn ? pinSync[PIN_PORT3_BIT6] : 1'b1;
        next_coreIn.adIn = pinSync[AD_BASE +: AD_COUNT];
        next_coreIn.serialIn = pinSync[PIN_PORT1_BIT2];
        next_coreIn.irqLine11 = pinSync[PIN_PORT1_BIT2];
        next_coreIn.serialClkIn = pinSync[PIN_PORT1_BIT4];
        next_coreIn.capture6 = pinSync[PIN_PORT4_BIT2];
        next_coreIn.canRx = pinSync[PIN_PORT4_BIT2];
        next_coreIn.irqLine9 = pinSync[PIN_PORT4_BIT2];
    end

    // register writes and reads
    always_comb begin
        next_ctrl = ctrl;
        next_portData = portData;
        next_portDir = portDir;
        next_portPull = portPull;
        next_regRdata = '0;
        pinLevel = pinSync;
        if (HAS_SUBCLOCK) begin
            pinLevel[PIN_PORT4_BIT0] = 1'b0;
            pinLevel[PIN_PORT4_BIT1] = 1'b0;
        end
        status = '0;
        status[STAT_HOLD_REQ] = coreIn.holdReq;
        status[STAT_READY] = coreIn.ready;
        status[STAT_EXT_BUS] = extBus;
        status[STAT_HOLD_ON] = holdOn;
        status[STAT_READY_ON] = readyOn;
        status[STAT_CLKOUT_ON] = clkOn;
        if (regWrite) begin
            if (regAddr == REG_CTRL) begin
                next_ctrl = regWdata[CTRL_BITS-1:0];
            end else if (regAddr == REG_DATA) begin
                next_portData = regWdata[PIN_COUNT-1:0];
            end else if (regAddr == REG_DIR) begin
                next_portDir = regWdata[PIN_COUNT-1:0];
            end else if (regAddr == REG_PULL) begin
                next_portPull = regWdata[PIN_COUNT-1:0];
            end
        end
        if (regRead) begin
            if (regAddr == REG_CTRL) begin
                next_regRdata = DATA_W'(ctrl);
            end else if (regAddr == REG_DATA) begin
                next_regRdata = DATA_W'(portData);
            end else if (regAddr == REG_DIR) begin
                next_regRdata = DATA_W'(portDir);
            end else if (regAddr == REG_PULL) begin
                next_regRdata = DATA_W'(portPull);
            end else if (regAddr == REG_PIN) begin
                next_regRdata = DATA_W'(pinLevel);
            end else if (regAddr == REG_STAT) begin
                next_regRdata = DATA_W'(status);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            portData <= PORT_RESET;
            portDir <= PORT_RESET;
            portPull <= PORT_RESET;
            regRdata <= '0;
            coreIn <= '0;
        end else begin
            ctrl <= next_ctrl;
            portData <= next_portData;
            portDir <= next_portDir;
            portPull <= next_portPull;
            regRdata <= next_regRdata;
            coreIn <= next_coreIn;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    pull_not_driven_a: assert property (!(|(pinPull & pinOe)))
        else $error("pull-up applied to a driven pin");
    hold_gpio_a: assert property (!holdOn && !ctrl[CTRL_CMP_LSB + 1] |=>
        pinOe[PIN_PORT3_BIT5] == $past(portDir[PIN_PORT3_BIT5]))
        else $error("hold acknowledge pin not a port pin");
    hold_req_gate_a: assert property (!holdOn |=> !coreIn.holdReq)
        else $error("hold request passed while hold off");
    hold_ack_drive_a: assert property (holdOn |=> pinOe[PIN_PORT3_BIT5] &&
        pinOut[PIN_PORT3_BIT5] == $past(busOut.holdAck))
        else $error("hold acknowledge not driven");
    ready_pin_a: assert property (readyOn && $past(readyOn) |->
        coreIn.ready == $past(pinIn[PIN_PORT3_BIT6], 3))
        else $error("ready input not sampled");
    ready_gate_a: assert property (!readyOn |=> coreIn.ready)
        else $error("ready input used while ready off");
    clk_gpio_a: assert property (!clkOn && !ctrl[CTRL_CMP_LSB + 3] |=>
        pinOe[PIN_PORT3_BIT7] == $past(portDir[PIN_PORT3_BIT7]))
        else $error("clock pin not a port pin");
    clk_out_a: assert property (clkOn |=> pinOe[PIN_PORT3_BIT7] &&
        pinOut[PIN_PORT3_BIT7] == $past(busOut.busClk))
        else $error("clock output not driven");
    cmp_wave_a: assert property (!holdOn && ctrl[CTRL_CMP_LSB] |=>
        pinOe[PIN_PORT3_BIT4] && pinOut[PIN_PORT3_BIT4] == $past(periphOut.cmpWave[0]))
        else $error("compare waveform not on pin");
    single_chip_a: assert property (!extBus |=>
        pinOe[PIN_PORT1_BIT6] == $past(portDir[PIN_PORT1_BIT6]))
        else $error("address/data pin not a port pin");
    bus_priority_a: assert property (extBus |=>
        pinOe[AD_BASE +: AD_COUNT] == $past(busOut.adOe))
        else $error("bus lines not owned by the bus");
    subclock_off_a: assert property (!HAS_SUBCLOCK ||
        (!pinOe[PIN_PORT4_BIT0] && !pinOe[PIN_PORT4_BIT1]))
        else $error("crystal pin driven");
    hold_req_gpio_a: assert property (!holdOn && !ctrl[CTRL_CMP_LSB] |=>
        pinOe[PIN_PORT3_BIT4] == $past(portDir[PIN_PORT3_BIT4]))
        else $error("hold request pin not a port pin");
    ready_gpio_a: assert property (!readyOn && !ctrl[CTRL_CMP_LSB + 2] |=>
        pinOe[PIN_PORT3_BIT6] == $past(portDir[PIN_PORT3_BIT6]))
        else $error("ready pin not a port pin");
    timer_out_a: assert property (!extBus && ctrl[CTRL_TIMER1] |=>
        pinOe[PIN_PORT1_BIT1] && pinOut[PIN_PORT1_BIT1] == $past(periphOut.timer1Out))
        else $error("timer output not on pin");
    serial_out_a: assert property (!extBus && ctrl[CTRL_SEROUT] |=>
        pinOe[PIN_PORT1_BIT3] && pinOut[PIN_PORT1_BIT3] == $past(periphOut.serialOut))
        else $error("serial output not on pin");
    serial_clk_a: assert property (!extBus && ctrl[CTRL_SERCLK] |=>
        pinOe[PIN_PORT1_BIT4] && pinOut[PIN_PORT1_BIT4] == $past(periphOut.serialClkOut))
        else $error("serial clock not on pin");
    serial_in_a: assert property ($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |->
        coreIn.serialIn == $past(pinIn[PIN_PORT1_BIT2], 3) && coreIn.irqLine11 == coreIn.serialIn)
        else $error("serial input not routed");
    capture_in_a: assert property ($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |->
        coreIn.capture6 == $past(pinIn[PIN_PORT4_BIT2], 3) && coreIn.canRx == coreIn.capture6 &&
        coreIn.irqLine9 == coreIn.capture6)
        else $error("capture input not routed");

    hold_seen_c: cover property (holdOn ##1 coreIn.holdReq);
    wait_seen_c: cover property (readyOn ##1 !coreIn.ready);
    serial_clk_c: cover property (!extBus && ctrl[CTRL_SERCLK] ##1 pinOe[PIN_PORT1_BIT4]);
    bus_switch_c: cover property (!extBus ##1 extBus);
endmodule
`default_nettype wire

// ==== verification/ebpm_board_model.sv ====
// Purpose: board side of the shared pins: bus master, slow device, memory
// Assumes: bench selects which pins the board drives and with what level
// Notes: released lines float to pull-up or to the inverse of the last level
`timescale 1ns/100ps
`default_nettype none
module ebpm_board_model
    import ebpm_pkg::*;
(
    // clock
    input wire logic clk,
    // device pads
    input wire logic [PIN_COUNT-1:0] pinOut,
    input wire logic [PIN_COUNT-1:0] pinOe,
    input wire logic [PIN_COUNT-1:0] pinPull,
    // board drivers
    input wire logic [PIN_COUNT-1:0] extVal,
    input wire logic [PIN_COUNT-1:0] extDrv,
    // resolved wire levels
    output logic [PIN_COUNT-1:0] pinLvl
);
    logic [PIN_COUNT-1:0] lastLvl = 13'h0000;

    always_ff @(posedge clk) begin
        lastLvl <= pinLvl;
    end

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (pinOe[i]) begin
                pinLvl[i] = pinOut[i];
            end else if (extDrv[i]) begin
                // hold master, ready device, memory, serial and irq sources
                pinLvl[i] = extVal[i];
            end else if (pinPull[i]) begin
                pinLvl[i] = 1'b1;
            end else begin
                pinLvl[i] = ~lastLvl[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_ext_bus_pin_function_mux.sv ====
// Purpose: self-checking bench for the shared-pin function mux
// Assumes: register port strobes, board model on the pins
// Notes: second instance covers the sub-clock variant
`timescale 1ns/100ps
`default_nettype none
module tb_ext_bus_pin_function_mux;
    import ebpm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdata;
    ebpm_bus_s busOut = '0;
    ebpm_periph_s periphOut = '0;
    ebpm_core_in_s coreIn;
    logic [PIN_COUNT-1:0] pinOut, pinOe, pinPull, pinLvl, subOe, subPull;
    logic [PIN_COUNT-1:0] extVal = 13'h0000;
    logic [PIN_COUNT-1:0] extDrv = 13'h0000;
    int numErrors = 0;
    int nChecks = 0;

    ebpm_pin_mux #(.DATA_W(16), .HAS_SUBCLOCK(1'b0)) ebpm_pin_mux_i (.clk(clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .busOut(busOut), .periphOut(periphOut), .coreIn(coreIn),
        .pinIn(pinLvl), .pinOut(pinOut), .pinOe(pinOe), .pinPull(pinPull));
    ebpm_pin_mux #(.DATA_W(16), .HAS_SUBCLOCK(1'b1)) ebpm_pin_mux_sub_i (.clk(clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(), .busOut(busOut), .periphOut(periphOut), .coreIn(),
        .pinIn(pinLvl), .pinOut(), .pinOe(subOe), .pinPull(subPull));
    ebpm_board_model ebpm_board_model_i (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
        .pinPull(pinPull), .extVal(extVal), .extDrv(extDrv), .pinLvl(pinLvl));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic regWr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task automatic regRd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, e);
        @(posedge clk);
        #1;
        chk(regRdata, 16'h0000);
    endtask

    task automatic cfg(input logic [15:0] c, input logic [15:0] dir, input logic [15:0] pull);
        regWr(REG_CTRL, c);
        regWr(REG_DIR, dir);
        regWr(REG_PULL, pull);
        settle();
    endtask

    task automatic t_gpio();
        regRd(REG_CTRL, 16'h0000);
        regWr(4'hA, 16'hFFFF);
        regRd(4'hA, 16'h0000);
        regWr(REG_DATA, 16'h0A5A);
        cfg(16'h0000, 16'h1FFF, 16'h0000);
        chk({3'h0, pinOe}, 16'h1FFF);
        chk({3'h0, pinOut}, 16'h0A5A);
        chk({14'h0000, subOe[5:4]}, 16'h0000);
        regRd(REG_DATA, 16'h0A5A);
        regRd(REG_DIR, 16'h1FFF);
        cfg(16'h0000, 16'h0000, 16'h1FFF);
        chk({3'h0, pinPull}, 16'h1FFF);
        chk({14'h0000, subPull[5:4]}, 16'h0000);
        regRd(REG_PULL, 16'h1FFF);
        regRd(REG_PIN, 16'h1FFF);
    endtask

    task automatic t_hold();
        busOut.holdAck <= 1'b0;
        periphOut.cmpWave <= 4'hA;
        extDrv <= 13'h0001;
        extVal <= 13'h0001;
        cfg(16'h00F3, 16'h0000, 16'h0000);
        chk({15'h0000, coreIn.holdReq}, 16'h0001);
        chk({12'h000, pinOe[3:0]}, 16'h000E);
        chk({12'h000, pinOut[3:1], 1'b0}, 16'h0008);
        regRd(REG_STAT, 16'h000F);
        busOut.holdAck <= 1'b1;
        settle();
        chk({15'h0000, pinOut[1]}, 16'h0001);
        cfg(16'h0002, 16'h0000, 16'h0000);
        chk({15'h0000, coreIn.holdReq}, 16'h0000);
        chk({15'h0000, pinOe[1]}, 16'h0000);
        cfg(16'h00F0, 16'h0000, 16'h0000);
        chk({12'h000, pinOe[3:0]}, 16'h000F);
        chk({12'h000, pinOut[3:0]}, 16'h000A);
    endtask

    task automatic t_ready();
        extDrv <= 13'h0004;
        extVal <= 13'h0000;
        cfg(16'h0005, 16'h0000, 16'h0000);
        chk({15'h0000, coreIn.ready}, 16'h0001 ^ 16'h0001);
        regRd(REG_STAT, 16'h0014);
        extVal <= 13'h0004;
        settle();
        chk({15'h0000, coreIn.ready}, 16'h0001);
        extVal <= 13'h0000;
        regWr(REG_DATA, 16'h0004);
        cfg(16'h0004, 16'h0004, 16'h0000);
        chk({15'h0000, coreIn.ready}, 16'h0001);
        chk({14'h0000, pinOe[2], pinOut[2]}, 16'h0003);
        extDrv <= 13'h0000;
    endtask

    task automatic t_clk();
        busOut.busClk <= 1'b1;
        cfg(16'h0009, 16'h0000, 16'h0000);
        chk({14'h0000, pinOe[3], pinOut[3]}, 16'h0003);
        regWr(REG_STAT, 16'hFFFF);
        regRd(REG_STAT, 16'h0026);
        busOut.busClk <= 1'b0;
        settle();
        chk({14'h0000, pinOe[3], pinOut[3]}, 16'h0002);
        cfg(16'h0008, 16'h0000, 16'h0000);
        chk({15'h0000, pinOe[3]}, 16'h0000);
    endtask

    task automatic t_bus();
        busOut.adOe <= 6'h3F;
        busOut.adOut <= 6'h2D;
        periphOut.timer1Out <= 1'b0;
        periphOut.serialOut <= 1'b1;
        periphOut.serialClkOut <= 1'b0;
        cfg(16'h0701, 16'h0000, 16'h0000);
        chk({10'h000, pinOe[12:7]}, 16'h003F);
        chk({10'h000, pinOut[12:7]}, 16'h002D);
        busOut.adOe <= 6'h00;
        extDrv <= 13'h1F80;
        extVal <= 13'h0A80;
        settle();
        chk({10'h000, coreIn.adIn}, 16'h0015);
        extDrv <= 13'h0000;
        periphOut.timer1Out <= 1'b1;
        periphOut.serialOut <= 1'b0;
        periphOut.serialClkOut <= 1'b1;
        cfg(16'h0700, 16'h0000, 16'h0000);
        chk({13'h0000, pinOe[7], pinOe[9], pinOe[10]}, 16'h0007);
        chk({13'h0000, pinOut[7], pinOut[9], pinOut[10]}, 16'h0005);
    endtask

    task automatic t_inputs();
        for (int v = 0; v < 2; v++) begin
            extDrv <= 13'h0540;
            extVal <= v[0] ? 13'h0540 : 13'h0000;
            cfg(16'h0000, 16'h0000, 16'h0000);
            chk({14'h0000, coreIn.serialIn, coreIn.irqLine11}, {14'h0000, {2{v[0]}}});
            chk({13'h0000, coreIn.capture6, coreIn.canRx, coreIn.irqLine9}, {13'h0000, {3{v[0]}}});
            chk({15'h0000, coreIn.serialClkIn}, {15'h0000, v[0]});
        end
        extDrv <= 13'h0000;
    endtask

    task automatic t_reset();
        cfg(16'h0701, 16'h1FFF, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        chk({3'h0, pinOe}, 16'h0000);
        chk({15'h0000, coreIn.ready}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({15'h0000, coreIn.ready}, 16'h0001);
        regRd(REG_CTRL, 16'h0000);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        numErrors++;
        results();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_gpio();
        t_hold();
        t_ready();
        t_clk();
        t_bus();
        t_inputs();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
